// ### rtl/sod_areg_mem.v
`timescale 1ns/1ps
`include "sod_map.vh"

module sod_areg_mem (
  // Clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // Write port
  input  wire        we,
  input  wire [2:0]  waddr,
  input  wire [31:0] wdata,
  // Registered read port
  input  wire [2:0]  raddr,
  output reg  [31:0] rdata
);

  reg [31:0] mem [0:7];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Entry zero always reads zero so indirect access through it acts direct
  always @(posedge mclk) begin
    if (!nrst) begin
      rdata <= 32'h0;
    end else if (raddr == `SOD_AREG_ZERO) begin
      rdata <= 32'h0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ### rtl/sod_decoder.v
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sod_map.vh"

module sod_decoder (
  // Clock and reset
  input  wire        mclk,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Fetch side
  input  wire        in_valid,
  output reg         in_ready,
  input  wire [31:0] in_word0,
  input  wire [31:0] in_word1,
  input  wire [1:0]  in_cond_kind,
  input  wire [1:0]  in_mem_kind,
  input  wire [1:0]  in_mem_shift,
  input  wire        in_long_off,
  input  wire [2:0]  in_src_kind,
  input  wire        in_is_cvt,
  input  wire [2:0]  in_dst_size,
  // Execute side
  input  wire        acc_done,
  output reg         iss_valid,
  output reg  [6:0]  iss_group,
  output reg         iss_is_mul,
  output reg  [2:0]  iss_itype,
  output reg         cond_we,
  output reg  [1:0]  cond_idx,
  output reg  [1:0]  dst_mode,
  output reg  [6:0]  dst_reg,
  output reg         dst_dup_half,
  output reg  [31:0] dst_oaddr,
  output reg         mem_valid,
  output reg  [31:0] mem_addr,
  output reg  [1:0]  mem_mode,
  output reg  [1:0]  mem_shift,
  output reg         mem_postinc,
  output reg  [2:0]  mem_areg,
  // Exception side
  output reg         err_valid,
  output reg  [2:0]  err_code
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE   = 2'b00;
  localparam ST_DECODE = 2'b01;
  localparam ST_WAIT   = 2'b10;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [2:0] itype_of;
    input [31:0] w0;
    input [31:0] w1;
    begin
      case (w0[`SOD_F_ITYPE])
        `SOD_W0_SHORT: itype_of = `SOD_IT_SN;
        `SOD_W0_SCTL:  itype_of = `SOD_IT_SC;
        `SOD_W0_LCTL:  itype_of = `SOD_IT_LC;
        default:       itype_of = (w1[`SOD_F_ITYPE] == `SOD_W1_IMM) ? `SOD_IT_LI : `SOD_IT_LN;
      endcase
    end
  endfunction

  function [2:0] areg_sel;
    input [2:0]  it;
    input [31:0] w0;
    input [31:0] w1;
    begin
      if (it == `SOD_IT_LN) begin
        areg_sel = {w1[`SOD_B_AHI], w0[`SOD_F_ALO]};
      end else begin
        areg_sel = {1'b0, w0[`SOD_F_ALO]};
      end
    end
  endfunction

  function [1:0] mode_shift;
    input [1:0] m;
    begin
      case (m)
        `SOD_SM_U8:  mode_shift = `SOD_SH_1;
        `SOD_SM_B32: mode_shift = `SOD_SH_4;
        default:     mode_shift = `SOD_SH_2;
      endcase
    end
  endfunction

  function [31:0] scaled;
    input [7:0] off;
    input [1:0] sh;
    begin
      scaled = {24'h0, off} << sh;
    end
  endfunction

  function opc_ok;
    input [2:0] it;
    input [3:0] p;
    input [2:0] s;
    reg   [15:0] m;
    begin
      case (it)
        `SOD_IT_SN: m = `SOD_MASK_SN;
        `SOD_IT_LI: m = (s == `SOD_SEC_ZERO) ? `SOD_MASK_LI : 16'h0000;
        `SOD_IT_SC: m = `SOD_MASK_SC;
        `SOD_IT_LC: m = `SOD_MASK_LC;
        default: begin
          case (s)
            3'h0:    m = `SOD_MASK_LN0;
            3'h1:    m = `SOD_MASK_LN1;
            3'h2:    m = `SOD_MASK_LN2;
            3'h3:    m = `SOD_MASK_LN3;
            3'h4:    m = `SOD_MASK_LN4;
            3'h5:    m = `SOD_MASK_LN5;
            3'h6:    m = `SOD_MASK_LN6;
            default: m = `SOD_MASK_LN7;
          endcase
        end
      endcase
      opc_ok = m[p];
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0]  st_reg;
  reg [1:0]  st_next;
  reg [31:0] w0_reg;
  reg [31:0] w1_reg;
  reg [2:0]  it_reg;
  reg [1:0]  ck_reg;
  reg [1:0]  mk_reg;
  reg [1:0]  msh_reg;
  reg        loff_reg;
  reg [2:0]  sk_reg;
  reg        cvt_reg;
  reg [2:0]  ds_reg;
  reg [2:0]  inc_idx_reg;
  reg [31:0] inc_val_reg;
  reg        ctrl_en_reg;
  reg [15:0] errcnt_reg;
  reg        apb_rd_reg;

  wire        accept   = in_valid & in_ready;
  wire [31:0] areg_q;
  wire        is_ln    = (it_reg == `SOD_IT_LN);
  wire        is_sd    = (it_reg == `SOD_IT_SN) | (it_reg == `SOD_IT_LI);
  wire [3:0]  prim     = w0_reg[`SOD_F_PRIM];
  wire [2:0]  sec      = is_ln ? w1_reg[`SOD_F_SEC] : `SOD_SEC_ZERO;
  wire [2:0]  sec_raw  = w1_reg[`SOD_F_SEC];
  wire [2:0]  aidx     = areg_sel(it_reg, w0_reg, w1_reg);
  wire        pinc     = w0_reg[`SOD_B_PINC];

  // ----------------------------------------
  // Memory operand decode
  // ----------------------------------------
  wire        shared   = (mk_reg == `SOD_MK_SHARED);
  wire        indirect = (mk_reg == `SOD_MK_INDIR) | shared;
  wire        has_mem  = (mk_reg != `SOD_MK_NONE);
  wire [1:0]  sh_mode  = is_ln ? w0_reg[`SOD_F_LSH_MODE] : w0_reg[`SOD_F_SSH_MODE];
  wire [7:0]  sh_off   = is_ln ? {3'h0, w0_reg[`SOD_F_LSH_OFF]} :
                                 {4'h0, w0_reg[`SOD_F_SSH_OFF]};
  wire [7:0]  pl_off   = loff_reg ? w0_reg[`SOD_F_LOFF] :
                         is_ln    ? {1'b0, w0_reg[`SOD_F_LSRC1]} :
                                    {2'h0, w0_reg[`SOD_F_SSRC1]};
  wire [1:0]  shift    = shared ? mode_shift(sh_mode) : msh_reg;
  wire [31:0] incr     = scaled(shared ? sh_off : pl_off, shift);
  wire [31:0] addr     = !indirect ? incr :
                         pinc      ? areg_q :
                                     areg_q + incr;

  wire e_size;
  wire e_sign;
  wire e_byte;

  sod_mode_chk u_mode_chk (
    .active   (shared),
    .kind     (sk_reg),
    .mode     (sh_mode),
    .is_cvt   (cvt_reg),
    .err_size (e_size),
    .err_sign (e_sign),
    .err_byte (e_byte)
  );

  // ----------------------------------------
  // Destination decode
  // ----------------------------------------
  wire [6:0]  long_word_dest     = w0_reg[`SOD_F_LONG_WORD_DEST];
  wire        dtype    = is_ln & w1_reg[`SOD_B_DTYPE];
  wire        dst_on   = (ds_reg != `SOD_DS_NONE);
  wire        dst_half = (ds_reg == `SOD_DS_HALF);
  reg  [1:0]  dm;
  reg  [6:0]  dr;
  reg  [31:0] doa;
  always @* begin
    dm  = `SOD_DM_NONE;
    dr  = 7'h00;
    doa = 32'h0;
    if (dst_on && is_sd) begin
      dm = `SOD_DM_REG;
      dr = {1'b0, w0_reg[`SOD_F_SHORT_WORD_DEST]};
    end else if (dst_on && is_ln) begin
      dr = long_word_dest;
      if (!dtype) begin
        dm = `SOD_DM_REG;
      end else if (long_word_dest == `SOD_DST_DISCARD) begin
        dm = `SOD_DM_DISCARD;
      end else begin
        dm = `SOD_DM_OSPACE;
        if (dst_half) begin
          doa = {24'h0, long_word_dest[6:1], 2'b00};
        end else begin
          doa = {23'h0, long_word_dest, 2'b00};
        end
      end
    end
  end

  wire e_align = is_ln & (dm == `SOD_DM_REG) &
                 (((ds_reg == `SOD_DS_PAIR) & long_word_dest[0]) |
                  ((ds_reg == `SOD_DS_QUAD) & (long_word_dest[1:0] != 2'b00)));

  // ----------------------------------------
  // Error priority
  // ----------------------------------------
  wire e_opc = !opc_ok(it_reg, prim, sec_raw);
  wire e_pi  = indirect & pinc & ((aidx == `SOD_AREG_ZERO) |
               (aidx == `SOD_AREG_NOPI5) | (aidx == `SOD_AREG_NOPI6));
  reg  [2:0] ecode;
  always @* begin
    if (e_opc) begin
      ecode = `SOD_ERR_OPCODE;
    end else if (e_pi) begin
      ecode = `SOD_ERR_POSTINC;
    end else if (e_size) begin
      ecode = `SOD_ERR_SIZE;
    end else if (e_sign) begin
      ecode = `SOD_ERR_SIGN;
    end else if (e_byte) begin
      ecode = `SOD_ERR_BYTE;
    end else if (e_align) begin
      ecode = `SOD_ERR_ALIGN;
    end else begin
      ecode = `SOD_ERR_NONE;
    end
  end
  wire any_err = (ecode != `SOD_ERR_NONE);
  wire pinc_go = !any_err & indirect & pinc;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire       hit_areg = (paddr[`SOD_F_AREG_PAGE] == `SOD_AREG_PAGE) &
                        (paddr[`SOD_F_WORD_LSB] == 2'b00);
  wire       hit_ctrl = (paddr == `SOD_A_CTRL);
  wire       hit_stat = (paddr == `SOD_A_STAT);
  wire       hit_cnt  = (paddr == `SOD_A_ERRCNT);
  wire       mapped   = hit_areg | hit_ctrl | hit_stat | hit_cnt;
  wire       apb_go   = psel & penable & !pready;
  wire       idle     = (st_reg == ST_IDLE);
  wire       apb_fin  = apb_go & (!hit_areg | (idle & (pwrite | apb_rd_reg)));
  wire       inc_wr   = (st_reg == ST_WAIT) & acc_done;
  wire       apb_awr  = apb_go & hit_areg & pwrite & idle;

  sod_areg_mem u_areg_mem (
    .mclk  (mclk),
    .nrst  (nrst),
    .we    (inc_wr | apb_awr),
    .waddr (inc_wr ? inc_idx_reg : paddr[`SOD_F_AREG_IDX]),
    .wdata (inc_wr ? inc_val_reg : pwdata),
    .raddr (accept ? areg_sel(itype_of(in_word0, in_word1), in_word0, in_word1) :
                     paddr[`SOD_F_AREG_IDX]),
    .rdata (areg_q)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    case (st_reg)
      ST_IDLE:   st_next = accept ? ST_DECODE : ST_IDLE;
      ST_DECODE: st_next = pinc_go ? ST_WAIT : ST_IDLE;
      ST_WAIT:   st_next = acc_done ? ST_IDLE : ST_WAIT;
      default:   st_next = ST_IDLE;
    endcase
  end

  // Fetch is held off while an address register waits for its increment and
  // while software reaches the address registers, so the read port is never shared
  always @(posedge mclk) begin
    if (!nrst) begin
      st_reg   <= ST_IDLE;
      in_ready <= 1'b0;
    end else begin
      st_reg   <= st_next;
      in_ready <= (st_next == ST_IDLE) & ctrl_en_reg & !(psel & hit_areg);
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      w0_reg   <= 32'h0;
      w1_reg   <= 32'h0;
      it_reg   <= `SOD_IT_SN;
      ck_reg   <= `SOD_CK_NONE;
      mk_reg   <= `SOD_MK_NONE;
      msh_reg  <= `SOD_SH_1;
      loff_reg <= 1'b0;
      sk_reg   <= `SOD_SK_WORD;
      cvt_reg  <= 1'b0;
      ds_reg   <= `SOD_DS_NONE;
    end else if (accept) begin
      w0_reg   <= in_word0;
      w1_reg   <= in_word1;
      it_reg   <= itype_of(in_word0, in_word1);
      ck_reg   <= in_cond_kind;
      mk_reg   <= in_mem_kind;
      msh_reg  <= in_mem_shift;
      loff_reg <= in_long_off;
      sk_reg   <= in_src_kind;
      cvt_reg  <= in_is_cvt;
      ds_reg   <= in_dst_size;
    end
  end

  // Increment is applied only once the execute stage reports the access done
  always @(posedge mclk) begin
    if (!nrst) begin
      inc_idx_reg <= `SOD_AREG_ZERO;
      inc_val_reg <= 32'h0;
    end else if ((st_reg == ST_DECODE) && pinc_go) begin
      inc_idx_reg <= aidx;
      inc_val_reg <= areg_q + incr;
    end
  end

  // ----------------------------------------
  // Issue and error outputs
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!nrst) begin
      iss_valid    <= 1'b0;
      iss_group    <= 7'h00;
      iss_is_mul   <= 1'b0;
      iss_itype    <= `SOD_IT_SN;
      cond_we      <= 1'b0;
      cond_idx     <= 2'h0;
      dst_mode     <= `SOD_DM_NONE;
      dst_reg      <= 7'h00;
      dst_dup_half <= 1'b0;
      dst_oaddr    <= 32'h0;
      mem_valid    <= 1'b0;
      mem_addr     <= 32'h0;
      mem_mode     <= `SOD_SM_U8;
      mem_shift    <= `SOD_SH_1;
      mem_postinc  <= 1'b0;
      mem_areg     <= `SOD_AREG_ZERO;
      err_valid    <= 1'b0;
      err_code     <= `SOD_ERR_NONE;
    end else if (st_reg == ST_DECODE) begin
      iss_valid    <= !any_err;
      err_valid    <= any_err;
      err_code     <= ecode;
      iss_group    <= {sec, prim};
      iss_is_mul   <= (prim == `SOD_PRIM_MUL) & (sec == `SOD_SEC_ZERO) &
                      (is_sd | is_ln);
      iss_itype    <= it_reg;
      cond_idx     <= w1_reg[`SOD_F_OPTIONAL_COND_DEST];
      cond_we      <= !any_err & is_ln & ((ck_reg == `SOD_CK_FORCED) |
                      ((ck_reg == `SOD_CK_OPT) & w1_reg[`SOD_B_CWE]));
      dst_mode     <= dm;
      dst_reg      <= dr;
      dst_dup_half <= (dm == `SOD_DM_OSPACE) & dst_half;
      dst_oaddr    <= doa;
      mem_valid    <= !any_err & has_mem;
      mem_addr     <= addr;
      mem_mode     <= shared ? sh_mode : `SOD_SM_U8;
      mem_shift    <= shift;
      mem_postinc  <= indirect & pinc;
      mem_areg     <= indirect ? aidx : `SOD_AREG_ZERO;
    end else begin
      iss_valid    <= 1'b0;
      err_valid    <= 1'b0;
      cond_we      <= 1'b0;
      mem_valid    <= 1'b0;
    end
  end

  // ----------------------------------------
  // APB registers
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!nrst) begin
      ctrl_en_reg <= `SOD_CTRL_RST;
      errcnt_reg  <= 16'h0000;
      apb_rd_reg  <= 1'b0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0;
    end else begin
      if ((st_reg == ST_DECODE) && any_err) begin
        errcnt_reg <= errcnt_reg + 16'h0001;
      end
      if (apb_go && hit_ctrl && pwrite) begin
        ctrl_en_reg <= pwdata[0];
      end
      if (pready) begin
        apb_rd_reg <= 1'b0;
      end else if (apb_go && hit_areg && !pwrite && idle) begin
        apb_rd_reg <= 1'b1;
      end
      pready  <= apb_fin;
      pslverr <= apb_fin & !mapped;
      if (apb_fin && !pwrite) begin
        if (hit_areg) begin
          prdata <= areg_q;
        end else if (hit_ctrl) begin
          prdata <= {31'h0, ctrl_en_reg};
        end else if (hit_stat) begin
          prdata <= {27'h0, err_code, st_reg};
        end else if (hit_cnt) begin
          prdata <= {16'h0, errcnt_reg};
        end else begin
          prdata <= 32'h0;
        end
      end
    end
  end

endmodule

// ### rtl/sod_map.vh
`ifndef SOD_MAP_VH
`define SOD_MAP_VH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define SOD_F_ITYPE     1:0
`define SOD_F_PRIM      31:28
`define SOD_F_SEC       31:29
`define SOD_F_OPTIONAL_COND_DEST      5:4
`define SOD_B_CWE       6
`define SOD_B_PINC      25
`define SOD_F_ALO       27:26
`define SOD_B_AHI       2
`define SOD_F_LOFF      16:9
`define SOD_F_SHORT_WORD_DEST      7:2
`define SOD_F_LONG_WORD_DEST      8:2
`define SOD_B_DTYPE     3
`define SOD_F_SSRC1     14:9
`define SOD_F_LSRC1     15:9
`define SOD_F_SSH_MODE  14:13
`define SOD_F_SSH_OFF   12:9
`define SOD_F_LSH_MODE  15:14
`define SOD_F_LSH_OFF   13:9

// ----------------------------------------
// Instruction types
// ----------------------------------------
`define SOD_W0_SHORT    2'h0
`define SOD_W0_SCTL     2'h2
`define SOD_W0_LCTL     2'h3
`define SOD_W1_IMM      2'h3
`define SOD_IT_SN       3'h0
`define SOD_IT_LN       3'h1
`define SOD_IT_LI       3'h2
`define SOD_IT_SC       3'h3
`define SOD_IT_LC       3'h4

// ----------------------------------------
// Valid primary opcodes per instruction type (bit n = primary n)
// ----------------------------------------
`define SOD_MASK_SN     16'hDBFE
`define SOD_MASK_LI     16'hF8DE
`define SOD_MASK_SC     16'h0A00
`define SOD_MASK_LC     16'h3FFF
`define SOD_MASK_LN0    16'hFFFF
`define SOD_MASK_LN1    16'hECC3
`define SOD_MASK_LN2    16'hF6C3
`define SOD_MASK_LN3    16'hFECB
`define SOD_MASK_LN4    16'hFEC9
`define SOD_MASK_LN5    16'hEEC9
`define SOD_MASK_LN6    16'hEEC9
`define SOD_MASK_LN7    16'hECC9
`define SOD_PRIM_MUL    4'h4
`define SOD_SEC_ZERO    3'h0

// ----------------------------------------
// Operand kinds from the predecoder
// ----------------------------------------
`define SOD_CK_NONE     2'h0
`define SOD_CK_FORCED   2'h1
`define SOD_CK_OPT      2'h2
`define SOD_MK_NONE     2'h0
`define SOD_MK_DIRECT   2'h1
`define SOD_MK_INDIR    2'h2
`define SOD_MK_SHARED   2'h3
`define SOD_SK_WORD     3'h0
`define SOD_SK_HALF     3'h1
`define SOD_SK_UHALF    3'h2
`define SOD_SK_SHALF    3'h3
`define SOD_SK_BYTE     3'h4
`define SOD_DS_NONE     3'h0
`define SOD_DS_WORD     3'h1
`define SOD_DS_HALF     3'h2
`define SOD_DS_PAIR     3'h3
`define SOD_DS_QUAD     3'h4

// ----------------------------------------
// Shared access modes and scale shifts
// ----------------------------------------
`define SOD_SM_U8       2'h0
`define SOD_SM_U16      2'h1
`define SOD_SM_S16      2'h2
`define SOD_SM_B32      2'h3
`define SOD_SH_1        2'h0
`define SOD_SH_2        2'h1
`define SOD_SH_4        2'h2

// ----------------------------------------
// Destination modes and special values
// ----------------------------------------
`define SOD_DM_NONE     2'h0
`define SOD_DM_REG      2'h1
`define SOD_DM_OSPACE   2'h2
`define SOD_DM_DISCARD  2'h3
`define SOD_DST_DISCARD 7'h7F
`define SOD_AREG_ZERO   3'h0
`define SOD_AREG_NOPI5  3'h5
`define SOD_AREG_NOPI6  3'h6

// ----------------------------------------
// Decode error codes
// ----------------------------------------
`define SOD_ERR_NONE    3'h0
`define SOD_ERR_OPCODE  3'h1
`define SOD_ERR_POSTINC 3'h2
`define SOD_ERR_SIZE    3'h3
`define SOD_ERR_SIGN    3'h4
`define SOD_ERR_BYTE    3'h5
`define SOD_ERR_ALIGN   3'h6

// ----------------------------------------
// APB register map
// ----------------------------------------
`define SOD_A_CTRL      8'h00
`define SOD_A_STAT      8'h04
`define SOD_A_ERRCNT    8'h08
`define SOD_F_AREG_PAGE 7:5
`define SOD_AREG_PAGE   3'h1
`define SOD_F_AREG_IDX  4:2
`define SOD_F_WORD_LSB  1:0
`define SOD_CTRL_RST    1'h1

`endif

// ### rtl/sod_mode_chk.v
`timescale 1ns/1ps
`include "sod_map.vh"

module sod_mode_chk (
  // Operand under test
  input  wire       active,
  input  wire [2:0] kind,
  input  wire [1:0] mode,
  input  wire       is_cvt,
  // Error flags
  output wire       err_size,
  output wire       err_sign,
  output wire       err_byte
);

  wire is16  = (kind == `SOD_SK_HALF) | (kind == `SOD_SK_UHALF) | (kind == `SOD_SK_SHALF);
  wire byte8 = (kind == `SOD_SK_BYTE);

  assign err_size = active & is16 & (mode == `SOD_SM_B32);
  assign err_sign = active & (((kind == `SOD_SK_UHALF) & (mode == `SOD_SM_S16)) |
                              ((kind == `SOD_SK_SHALF) & (mode == `SOD_SM_U16)));
  // Byte sources only appear on conversions; any wider mode is refused whether is_cvt is set or not
  assign err_byte = active & byte8 & (mode != `SOD_SM_U8) & (is_cvt | 1'b1);

endmodule

// ### tb/sod_decoder_checker.sv
`timescale 1ns/1ps
`include "sod_map.vh"
module sod_checker (
  // Clock and reset
  input logic       mclk,
  input logic       nrst,
  // Watched ports
  input logic       in_valid,
  input logic       in_ready,
  input logic       acc_done,
  input logic       iss_valid,
  input logic       cond_we,
  input logic       mem_valid,
  input logic       mem_postinc,
  input logic       pready,
  input logic       pslverr,
  input logic       err_valid,
  input logic [2:0] err_code
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ------
  // Post-increment wait
  // ------
  logic wait_reg;
  always @(posedge mclk)
    wait_reg <= nrst && !acc_done && (wait_reg || (iss_valid && mem_postinc));

  property p_answer; in_valid && in_ready |-> ##2 (iss_valid || err_valid); endproperty
  property p_single; !(iss_valid && err_valid); endproperty
  property p_code; err_valid |-> err_code != `SOD_ERR_NONE; endproperty
  property p_cond; cond_we |-> iss_valid; endproperty
  property p_mem; mem_valid |-> iss_valid; endproperty
  property p_gap; in_valid && in_ready |=> !in_ready; endproperty
  property p_stall; wait_reg |-> !in_ready; endproperty
  property p_resume; wait_reg && acc_done |=> in_ready; endproperty
  a_answer: assert property (p_answer) else $error("no decode answer");
  a_single: assert property (p_single) else $error("issue and error together");
  a_code: assert property (p_code) else $error("error without code");
  a_cond: assert property (p_cond) else $error("cond write without issue");
  a_mem: assert property (p_mem) else $error("memory access without issue");
  a_gap: assert property (p_gap) else $error("second take too soon");
  a_stall: assert property (p_stall) else $error("ready while access pending");
  a_resume: assert property (p_resume) else $error("no ready after access");
  c_err: cover property (err_valid && err_code == `SOD_ERR_POSTINC);
  c_pinc: cover property (wait_reg && acc_done);
  c_slverr: cover property (pready && pslverr);
endmodule

bind sod_decoder sod_checker chk_u (.*);

// ### tb/sod_decoder_tb.sv
`timescale 1ns/1ps
`include "sod_map.vh"
module sod_decoder_tb;
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, in_valid, in_ready, e;
  logic        in_long_off, in_is_cvt, acc_done, iss_valid, iss_is_mul, cond_we, dst_dup_half;
  logic        mem_valid, mem_postinc, err_valid;
  logic [1:0]  in_cond_kind, in_mem_kind, in_mem_shift, cond_idx, dst_mode, mem_mode, mem_shift;
  logic [2:0]  in_src_kind, in_dst_size, iss_itype, mem_areg, err_code, x;
  logic [3:0]  lat;
  logic [6:0]  iss_group, dst_reg;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, in_word0, in_word1, dst_oaddr, mem_addr, r;
  int          n_mismatch, checked, n_err, i, j, s;

  sod_decoder dut_u (.*);
  sod_exec_model exec_u (.mclk(mclk), .nrst(nrst), .go(iss_valid & mem_postinc), .lat(lat),
                         .acc_done(acc_done));

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  task end_sim;
    $display("Checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] xe, g);
    checked++;
    if (g !== xe) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, xe, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      k++;
    end while (!pready && k < 50);
    chk("pready", 1, pready);
    if (!pready)
      end_sim;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task dec(input logic [31:0] a, b, input logic [13:0] k, input logic [2:0] xe);
    int t;
    t = 0;
    @(posedge mclk);
    {in_valid, in_word0, in_word1} <= {1'h1, a, b};
    {in_cond_kind, in_mem_kind, in_mem_shift, in_long_off, in_src_kind, in_is_cvt,
     in_dst_size} <= k;
    do begin
      @(posedge mclk);
      t++;
    end while (!in_ready && t < 60);
    chk("in_ready", 1, in_ready);
    if (!in_ready)
      end_sim;
    in_valid <= 1'h0;
    @(posedge mclk);
    #1;
    chk("err_code", xe, err_valid ? err_code : iss_valid ? 3'h0 : 3'h7);
    n_err += (xe != 0);
  endtask

  function logic [31:0] lw0(input logic [3:0] p, input logic [1:0] al, input logic pi,
                            input logic [7:0] of, input logic [6:0] d);
    return {p, al, pi, 8'h00, of, d, 2'h1};
  endfunction
  function logic [31:0] lw1(input logic [2:0] sc, input logic we, input logic [1:0] c,
                            input logic t, ah);
    return {sc, 22'h000000, we, c, t, ah, 2'h0};
  endfunction
  function logic [31:0] sw0(input logic [3:0] p, input logic [1:0] al, input logic [5:0] sr, d);
    return {p, al, 11'h000, sr, 1'h0, d, 2'h0};
  endfunction
  function logic [13:0] kd(input logic [1:0] c, m, sh, input logic l, input logic [2:0] k,
                           input logic v, input logic [2:0] d);
    return {c, m, sh, l, k, v, d};
  endfunction

  task dd(input logic [2:0] sz, input logic t, input logic [6:0] d, input logic [2:0] xe,
          input logic [1:0] m, input logic [31:0] a);
    dec(lw0(1, 0, 0, 0, d), lw1(0, 0, 0, t, 0), kd(0, 0, 0, 0, 0, 0, sz), xe);
    if (xe == 0)
      chk("dst_mode", m, dst_mode);
    if (m == `SOD_DM_REG)
      chk("dst_reg", d, dst_reg);
    if (m == `SOD_DM_OSPACE)
      chk("dst_oaddr", a, dst_oaddr);
  endtask

  // ------
  // Tests
  // ------
  initial begin
    {nrst, psel, penable, pwrite, in_valid, in_long_off, in_is_cvt, paddr, pwdata, lat} = '0;
    {in_word0, in_word1, in_cond_kind, in_mem_kind, in_mem_shift, in_src_kind, in_dst_size} = '0;
    repeat (12) @(posedge mclk);
    nrst <= 1'h1;
    apb(0, `SOD_A_CTRL, 0);
    chk("ctrl", 1, r);
    apb(1, 8'h24, 32'h100);
    apb(1, 8'h34, 32'h200);
    apb(1, 8'h20, 32'h55);
    apb(1, `SOD_A_ERRCNT, 32'hFF);
    apb(0, 8'h24, 0);
    chk("areg1", 32'h100, r);
    apb(0, 8'h20, 0);
    chk("areg0", 0, r);
    apb(0, `SOD_A_ERRCNT, 0);
    chk("errcnt", 0, r);
    apb(0, 8'h40, 0);
    chk("slverr", 1, e);
    apb(1, `SOD_A_CTRL, 0);
    @(posedge mclk);
    chk("in_ready", 0, in_ready);
    apb(1, `SOD_A_CTRL, 1);
    $display("Test registers done");
    for (i = 0; i < 3; i++) begin
      dec(lw0(4, 0, 0, 0, 10), lw1(0, i == 2, i + 1, 0, 0), kd(i ? 2 : 1, 0, 0, 0, 0, 0, 1), 0);
      chk("cond_we", i != 1, cond_we);
      chk("cond_idx", i + 1, cond_idx);
      chk("iss_is_mul", 1, iss_is_mul);
      chk("dst_reg", 10, dst_reg);
    end
    dec(sw0(4, 0, 0, 63), 32'hFF, kd(0, 0, 0, 0, 0, 0, 1), 0);
    chk("dst_reg", 63, dst_reg);
    chk("iss_is_mul", 1, iss_is_mul);
    dec(lw0(4, 0, 0, 0, 5), 32'h3, kd(0, 0, 0, 0, 0, 0, 1), 0);
    chk("iss_is_mul", 1, iss_is_mul);
    dec(32'h2, 0, 0, `SOD_ERR_OPCODE);
    dec(lw0(4, 0, 0, 0, 0), 32'h20000003, 0, `SOD_ERR_OPCODE);
    dec(lw0(4, 0, 0, 0, 0), lw1(1, 0, 0, 0, 0), 0, `SOD_ERR_OPCODE);
    $display("Test condition and opcode done");
    dd(1, 1, 127, 0, `SOD_DM_DISCARD, 0);
    dd(2, 1, 127, 0, `SOD_DM_DISCARD, 0);
    dd(1, 1, 126, 0, `SOD_DM_OSPACE, 32'h1F8);
    dd(2, 1, 7, 0, `SOD_DM_OSPACE, 12);
    chk("dst_dup_half", 1, dst_dup_half);
    dd(1, 0, 100, 0, `SOD_DM_REG, 0);
    dd(3, 0, 3, `SOD_ERR_ALIGN, 0, 0);
    dd(4, 0, 6, `SOD_ERR_ALIGN, 0, 0);
    dd(4, 0, 8, 0, `SOD_DM_REG, 0);
    $display("Test destinations done");
    dec(lw0(1, 0, 0, 5, 0), 0, kd(0, 1, 2, 1, 0, 0, 1), 0);
    chk("mem_addr", 20, mem_addr);
    dec(lw0(1, 1, 0, 3, 0), lw1(0, 0, 0, 0, 1), kd(0, 2, 1, 1, 0, 0, 1), 0);
    chk("mem_addr", 32'h206, mem_addr);
    chk("mem_areg", 5, mem_areg);
    dec(sw0(1, 1, 3, 0), 32'h4, kd(0, 2, 1, 0, 0, 0, 1), 0);
    chk("mem_addr", 32'h106, mem_addr);
    lat <= 4'h9;
    dec(lw0(1, 1, 1, 3, 0), 0, kd(0, 2, 1, 1, 0, 0, 1), 0);
    chk("mem_addr", 32'h100, mem_addr);
    chk("mem_postinc", 1, mem_postinc);
    dec(lw0(1, 1, 1, 2, 0), 0, kd(0, 2, 2, 1, 0, 0, 1), 0);
    chk("mem_addr", 32'h106, mem_addr);
    lat <= 4'h0;
    dec(lw0(1, 1, 0, 0, 0), 0, kd(0, 2, 2, 1, 0, 0, 1), 0);
    chk("mem_addr", 32'h10E, mem_addr);
    for (i = 0; i < 3; i++) begin
      j = i ? i + 4 : 0;
      dec(lw0(1, j[1:0], 1, 1, 0), lw1(0, 0, 0, 0, j[2]), kd(0, 2, 0, 1, 0, 0, 1), 2);
    end
    $display("Test addressing done");
    for (i = 0; i < 5; i++)
      for (j = 0; j < (i == 4 ? 3 : 4); j++) begin
        x = i == 0 ? 0 : i == 4 ? (j ? 5 : 0) : j == 3 ? 3 : (i + j == 4 && i > 1) ? 4 : 0;
        s = j == 0 ? 0 : j == 3 ? 2 : 1;
        dec(lw0(10, 0, 0, {j[1:0], 5'h3}, 0), 0, kd(0, 3, 0, 0, i, i > 3, 1), x);
        if (x == 0) begin
          chk("mem_mode", j, mem_mode);
          chk("mem_shift", s, mem_shift);
          chk("mem_addr", 3 << s, mem_addr);
        end
      end
    apb(0, `SOD_A_ERRCNT, 0);
    chk("errcnt", n_err, r);
    $display("Test shared modes done");
    end_sim;
  end
endmodule

// ### tb/sod_exec_model.sv
`timescale 1ns/1ps
module sod_exec_model (
  // Clock and reset
  input  logic       mclk,
  input  logic       nrst,
  // Post-increment issue, latency
  input  logic       go,
  input  logic [3:0] lat,
  // Access finished
  output logic       acc_done
);
  logic       busy_reg;
  logic [3:0] cnt_reg;
  // One completion per access
  always @(posedge mclk) begin
    acc_done <= nrst && !go && busy_reg && cnt_reg == 4'h0;
    busy_reg <= nrst && (go || (busy_reg && cnt_reg != 4'h0));
    cnt_reg  <= go ? lat : cnt_reg - 4'h1;
  end
endmodule
